// >>> core/ccrc_cache_div.sv
// Cache SRAM clock divider: core clock divided by 1, 1.5, 2, 2.5 or 3
`timescale 1ns/10ps
module ccrc_cache_div
  import ccrc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [CDIV_W-1:0] div_sel,
  output logic                   cache_clk_en
);

  // Divisor in half core cycles; core period counted as two half steps
  function automatic logic [HCNT_W-1:0] half_steps(input logic [CDIV_W-1:0] sel);
    case (sel)
      CDIV_1X0: half_steps = 3'h2;
      CDIV_1X5: half_steps = 3'h3;
      CDIV_2X0: half_steps = 3'h4;
      CDIV_2X5: half_steps = 3'h5;
      CDIV_3X0: half_steps = 3'h6;
      default:  half_steps = HCNT_ZERO;
    endcase
  endfunction

  logic [HCNT_W:0]   acc_r;
  logic [HCNT_W:0]   acc_nxt;
  logic              tick_r;
  logic              tick_nxt;
  logic [HCNT_W-1:0] step;

  // Fractional accumulator: two half units per core cycle, tick on each wrap.
  // Non-integer ratios give an uneven pulse spacing; the average rate is exact.
  always_comb begin
    step     = half_steps(div_sel);
    acc_nxt  = acc_r + {{HCNT_W{1'b0}}, 1'b1} + {{HCNT_W{1'b0}}, 1'b1};
    tick_nxt = 1'b0;
    if (step == HCNT_ZERO) begin
      acc_nxt = '0;
    end else if (acc_nxt >= {1'b0, step}) begin
      acc_nxt  = acc_nxt - {1'b0, step};
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      acc_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign cache_clk_en = tick_r;

endmodule

// >>> core/ccrc_top.sv
// Core clock ratio control: strap decode, mode, cache clock divide, feedback align
`timescale 1ns/10ps
module ccrc_top
  import ccrc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [RSEL_W-1:0] ratio_sel,
  input  wire logic [CDIV_W-1:0] cache_clock_divisor,
  input  wire logic              slow_cache_clock_flag,
  input  wire logic              cache_clock_feedback_in,
  output logic [HALF_W-1:0]      core_mult_half,
  output logic [VCO_W-1:0]       vco_mult_half,
  output logic                   pll_enable,
  output logic                   pll_bypass,
  output logic                   core_clock_run,
  output logic                   ratio_reserved,
  output logic                   cache_clock_out,
  output logic                   cache_clock_feedback_out,
  output logic                   cache_slow_mode,
  output logic                   feedback_locked,
  output logic                   feedback_lead
);

  // Strap decode to bus-to-core multiplier in half units
  function automatic logic [HALF_W-1:0] decode_mult(input logic [RSEL_W-1:0] code);
    case (code)
      RSEL_2X0:  decode_mult = HALF_2X0;
      RSEL_3X0:  decode_mult = HALF_3X0;
      RSEL_3X5:  decode_mult = HALF_3X5;
      RSEL_4X0:  decode_mult = HALF_4X0;
      RSEL_4X5:  decode_mult = HALF_4X5;
      RSEL_5X0:  decode_mult = HALF_5X0;
      RSEL_5X5:  decode_mult = HALF_5X5;
      RSEL_6X0:  decode_mult = HALF_6X0;
      RSEL_6X5:  decode_mult = HALF_6X5;
      RSEL_7X0:  decode_mult = HALF_7X0;
      RSEL_7X5:  decode_mult = HALF_7X5;
      RSEL_8X0:  decode_mult = HALF_8X0;
      RSEL_10X0: decode_mult = HALF_10X0;
      RSEL_BYP:  decode_mult = HALF_1X0;
      default:   decode_mult = HALF_NONE;
    endcase
  endfunction

  // Mode from strap; reserved codes stop the core just like off
  function automatic ccrc_mode_t decode_mode(input logic [RSEL_W-1:0] code);
    if (code == RSEL_BYP) begin
      decode_mode = CCRC_MODE_BYPASS;
    end else if (code == RSEL_OFF) begin
      decode_mode = CCRC_MODE_OFF;
    end else if (decode_mult(code) == HALF_NONE) begin
      decode_mode = CCRC_MODE_RSVD;
    end else begin
      decode_mode = CCRC_MODE_PLL;
    end
  endfunction

  ccrc_mode_t        mode_r;
  ccrc_mode_t        mode_nxt;
  logic [RSEL_W-1:0] strap_r;
  logic [RSEL_W-1:0] strap_nxt;
  logic [HALF_W-1:0] mult_r;
  logic [HALF_W-1:0] mult_nxt;
  logic [VCO_W-1:0]  vco_r;
  logic [VCO_W-1:0]  vco_nxt;
  logic              pll_en_r;
  logic              pll_en_nxt;
  logic              byp_r;
  logic              byp_nxt;
  logic              run_r;
  logic              run_nxt;
  logic              rsvd_r;
  logic              rsvd_nxt;
  logic              strap_taken_r;
  logic              strap_taken_nxt;

  // Strap caught once on the first edge after reset release. Holding it
  // avoids a ratio change mid-run if the board strap glitches.
  always_comb begin
    strap_taken_nxt = 1'b1;
    strap_nxt       = strap_taken_r ? strap_r : ratio_sel;
    mode_nxt        = decode_mode(strap_nxt);
    mult_nxt        = decode_mult(strap_nxt);
    vco_nxt         = '0;
    pll_en_nxt      = 1'b0;
    byp_nxt         = 1'b0;
    run_nxt         = 1'b0;
    rsvd_nxt        = 1'b0;
    case (mode_nxt)
      CCRC_MODE_PLL: begin
        pll_en_nxt = 1'b1;
        run_nxt    = 1'b1;
        vco_nxt    = {1'b0, mult_nxt} << VCO_SHIFT;
      end
      CCRC_MODE_BYPASS: begin
        byp_nxt = 1'b1;
        run_nxt = 1'b1;
      end
      CCRC_MODE_OFF: begin
        run_nxt = 1'b0;
      end
      CCRC_MODE_RSVD: begin
        rsvd_nxt = 1'b1;
      end
      default: begin
        rsvd_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      strap_taken_r <= 1'b0;
      strap_r       <= '0;
      mode_r        <= CCRC_MODE_OFF;
      mult_r        <= '0;
      vco_r         <= '0;
      pll_en_r      <= 1'b0;
      byp_r         <= 1'b0;
      run_r         <= 1'b0;
      rsvd_r        <= 1'b0;
    end else begin
      strap_taken_r <= strap_taken_nxt;
      strap_r       <= strap_nxt;
      mode_r        <= mode_nxt;
      mult_r        <= mult_nxt;
      vco_r         <= vco_nxt;
      pll_en_r      <= pll_en_nxt;
      byp_r         <= byp_nxt;
      run_r         <= run_nxt;
      rsvd_r        <= rsvd_nxt;
    end
  end

  // Cache clock divider; held idle while the core is not clocked
  logic [CDIV_W-1:0] div_sel;
  logic              div_tick;

  assign div_sel = run_r ? cache_clock_divisor : CDIV_OFF;

  ccrc_cache_div u_div (
    .clock        (clock),
    .rst          (rst),
    .div_sel      (div_sel),
    .cache_clk_en (div_tick)
  );

  logic cclk_r;
  logic cclk_nxt;
  logic fbo_r;
  logic fbo_nxt;
  logic slow_r;
  logic slow_nxt;

  // Cache clock and its feedback copy toggle together on each divider tick
  always_comb begin
    cclk_nxt = div_tick ? ~cclk_r : cclk_r;
    fbo_nxt  = div_tick ? ~fbo_r : fbo_r;
    slow_nxt = slow_cache_clock_flag;
    if (!run_r) begin
      cclk_nxt = 1'b0;
      fbo_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cclk_r <= 1'b0;
      fbo_r  <= 1'b0;
      slow_r <= 1'b0;
    end else begin
      cclk_r <= cclk_nxt;
      fbo_r  <= fbo_nxt;
      slow_r <= slow_nxt;
    end
  end

  // Feedback return compare: digital stand-in for the delay loop. Counts
  // mismatches between returned and sent edges; lock when error settles.
  logic              fbi_r;
  logic              fbi_nxt;
  logic [PERR_W-1:0] perr_r;
  logic [PERR_W-1:0] perr_nxt;
  logic              lock_r;
  logic              lock_nxt;
  logic              lead_r;
  logic              lead_nxt;

  always_comb begin
    fbi_nxt  = cache_clock_feedback_in;
    perr_nxt = perr_r;
    lead_nxt = lead_r;
    if (fbi_r != fbo_r) begin
      lead_nxt = fbo_r;
      if (perr_r != '1) begin
        perr_nxt = perr_r + {{(PERR_W-1){1'b0}}, 1'b1};
      end
    end else if (perr_r != '0) begin
      perr_nxt = perr_r - {{(PERR_W-1){1'b0}}, 1'b1};
    end
    lock_nxt = run_r && (perr_nxt == '0);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fbi_r  <= 1'b0;
      perr_r <= '0;
      lock_r <= 1'b0;
      lead_r <= 1'b0;
    end else begin
      fbi_r  <= fbi_nxt;
      perr_r <= perr_nxt;
      lock_r <= lock_nxt;
      lead_r <= lead_nxt;
    end
  end

  // All outputs straight from flip-flops
  assign core_mult_half           = mult_r;
  assign vco_mult_half            = vco_r;
  assign pll_enable               = pll_en_r;
  assign pll_bypass               = byp_r;
  assign core_clock_run           = run_r;
  assign ratio_reserved           = rsvd_r;
  assign cache_clock_out          = cclk_r;
  assign cache_clock_feedback_out = fbo_r;
  assign cache_slow_mode          = slow_r;
  assign feedback_locked          = lock_r;
  assign feedback_lead            = lead_r;

endmodule

// >>> inc/ccrc_pkg.sv
// Package for the core clock ratio control block: codes, encodings, widths
package ccrc_pkg;

  // Ratio select strap width and codes
  localparam int unsigned RSEL_W = 4;
  localparam logic [3:0] RSEL_2X0  = 4'h4;
  localparam logic [3:0] RSEL_3X0  = 4'h8;
  localparam logic [3:0] RSEL_3X5  = 4'he;
  localparam logic [3:0] RSEL_4X0  = 4'ha;
  localparam logic [3:0] RSEL_4X5  = 4'h7;
  localparam logic [3:0] RSEL_5X0  = 4'hb;
  localparam logic [3:0] RSEL_5X5  = 4'h9;
  localparam logic [3:0] RSEL_6X0  = 4'hd;
  localparam logic [3:0] RSEL_6X5  = 4'h5;
  localparam logic [3:0] RSEL_7X0  = 4'h2;
  localparam logic [3:0] RSEL_7X5  = 4'h1;
  localparam logic [3:0] RSEL_8X0  = 4'hc;
  localparam logic [3:0] RSEL_10X0 = 4'h6;
  localparam logic [3:0] RSEL_BYP  = 4'h3;
  localparam logic [3:0] RSEL_OFF  = 4'hf;

  // Multipliers are held in half units (2x is 4, 3.5x is 7)
  localparam int unsigned HALF_W = 5;
  localparam logic [4:0] HALF_NONE = 5'h00;
  localparam logic [4:0] HALF_1X0  = 5'h02;
  localparam logic [4:0] HALF_2X0  = 5'h04;
  localparam logic [4:0] HALF_3X0  = 5'h06;
  localparam logic [4:0] HALF_3X5  = 5'h07;
  localparam logic [4:0] HALF_4X0  = 5'h08;
  localparam logic [4:0] HALF_4X5  = 5'h09;
  localparam logic [4:0] HALF_5X0  = 5'h0a;
  localparam logic [4:0] HALF_5X5  = 5'h0b;
  localparam logic [4:0] HALF_6X0  = 5'h0c;
  localparam logic [4:0] HALF_6X5  = 5'h0d;
  localparam logic [4:0] HALF_7X0  = 5'h0e;
  localparam logic [4:0] HALF_7X5  = 5'h0f;
  localparam logic [4:0] HALF_8X0  = 5'h10;
  localparam logic [4:0] HALF_10X0 = 5'h14;

  // VCO runs at twice core: VCO multiplier in half units is core half value shifted left by this
  localparam int unsigned VCO_W = 6;
  localparam int unsigned VCO_SHIFT = 1;

  // Cache clock divisor field encoding (divisor in half units 2,3,4,5,6)
  localparam int unsigned CDIV_W = 3;
  localparam logic [2:0] CDIV_1X0 = 3'h1;
  localparam logic [2:0] CDIV_1X5 = 3'h2;
  localparam logic [2:0] CDIV_2X0 = 3'h3;
  localparam logic [2:0] CDIV_2X5 = 3'h4;
  localparam logic [2:0] CDIV_3X0 = 3'h5;
  localparam logic [2:0] CDIV_OFF = 3'h0;

  // Divider half-period counts in core clock edges (both edges, so half units)
  localparam int unsigned HCNT_W = 3;
  localparam logic [2:0] HCNT_ZERO = 3'h0;
  localparam logic [2:0] HCNT_ONE  = 3'h1;

  // Feedback alignment: phase error counter width
  localparam int unsigned PERR_W = 4;

  // Clock mode of the core
  typedef enum logic [1:0] {
    CCRC_MODE_PLL,
    CCRC_MODE_BYPASS,
    CCRC_MODE_OFF,
    CCRC_MODE_RSVD
  } ccrc_mode_t;

endpackage

// >>> verif/ccrc_board_model.sv
// Board model: returns the feedback clock over a trace of selectable lag
`timescale 1ns/10ps
module ccrc_board_model (
  input  wire logic       clock,
  input  wire logic [1:0] lag,
  input  wire logic       fb_out,
  output logic            fb_in
);
  logic [2:0] line_r;

  // Trace delay line; a long trace models a slow return path
  always_ff @(posedge clock) begin
    line_r <= {line_r[1:0], fb_out};
  end

  // Returned clock picked by lag, zero is a direct wire
  assign fb_in = (lag == 2'h0) ? fb_out : line_r[lag - 2'h1];
endmodule

// >>> verif/ccrc_top_chk.sv
// Port checker for the core clock ratio control block
`timescale 1ns/10ps
module ccrc_top_chk
  import ccrc_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic [RSEL_W-1:0] ratio_sel,
  input wire logic [CDIV_W-1:0] cache_clock_divisor,
  input wire logic              slow_cache_clock_flag,
  input wire logic              cache_clock_feedback_in,
  input wire logic [HALF_W-1:0] core_mult_half,
  input wire logic [VCO_W-1:0]  vco_mult_half,
  input wire logic              pll_enable,
  input wire logic              pll_bypass,
  input wire logic              core_clock_run,
  input wire logic              ratio_reserved,
  input wire logic              cache_clock_out,
  input wire logic              cache_clock_feedback_out,
  input wire logic              cache_slow_mode,
  input wire logic              feedback_locked,
  input wire logic              feedback_lead
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Decode relations; strap is only trusted from the second edge after release
  vco_double_a: assert property (pll_enable |-> vco_mult_half == {core_mult_half, 1'b0})
    else $error("vco multiplier not twice core");
  dec_stand_a: assert property (!$past(rst) && !$past(rst, 2)
    |-> $stable(core_mult_half) && $stable(ratio_reserved))
    else $error("decode outputs moved after capture");
  byp_mode_a: assert property (pll_bypass
    |-> core_clock_run && !pll_enable && core_mult_half == HALF_1X0)
    else $error("bypass mode outputs wrong");
  off_strap_a: assert property (!$past(rst) && ratio_sel == RSEL_OFF
    |-> !core_clock_run && !pll_enable && !pll_bypass)
    else $error("off strap still clocks core");
  rsvd_code_a: assert property (ratio_reserved
    |-> !core_clock_run && core_mult_half == HALF_NONE)
    else $error("reserved code clocks core");

  // Divider: divide by one toggles each cycle, stop code holds level
  div_one_a: assert property ((core_clock_run && cache_clock_divisor == CDIV_1X0)[*4]
    |-> cache_clock_out != $past(cache_clock_out))
    else $error("divide by one did not toggle");
  div_stop_a: assert property ((cache_clock_divisor == CDIV_OFF)[*3]
    |-> $stable(cache_clock_out))
    else $error("stopped divider moved");

  // Feedback path and slow flag
  fb_copy_a: assert property (cache_clock_feedback_out == cache_clock_out)
    else $error("feedback out differs from cache clock");
  lock_run_a: assert property (feedback_locked |-> core_clock_run)
    else $error("locked without core clock");
  slow_reg_a: assert property (!$past(rst)
    |-> cache_slow_mode == $past(slow_cache_clock_flag))
    else $error("slow mode not one cycle behind flag");

  // Main scenarios reached
  cov_byp: cover property (pll_bypass);
  cov_rsvd: cover property (ratio_reserved);
  cov_lock: cover property (feedback_locked && cache_clock_divisor == CDIV_OFF);
endmodule

// >>> verif/ccrc_top_tb.sv
// Self-checking bench for the core clock ratio control block
`timescale 1ns/10ps
module ccrc_top_tb
  import ccrc_pkg::*;
;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] ratio_sel = RSEL_2X0;
  logic [2:0] div = CDIV_1X0;
  logic       slow = 1'b0;
  logic [1:0] lag = 2'h0;
  logic       fbi;
  logic [4:0] mult;
  logic [5:0] vco;
  logic       pll_en, byp, run, rsvd, cco, fbo, slow_m, lock, lead;
  int         failures = 0;
  int         n_tests = 0;

  // 100 MHz clock
  always #5 clock = ~clock;

  ccrc_top dut (.clock(clock), .rst(rst), .ratio_sel(ratio_sel), .cache_clock_divisor(div),
    .slow_cache_clock_flag(slow), .cache_clock_feedback_in(fbi), .core_mult_half(mult),
    .vco_mult_half(vco), .pll_enable(pll_en), .pll_bypass(byp), .core_clock_run(run),
    .ratio_reserved(rsvd), .cache_clock_out(cco), .cache_clock_feedback_out(fbo),
    .cache_slow_mode(slow_m), .feedback_locked(lock), .feedback_lead(lead));
  ccrc_board_model board (.clock(clock), .lag(lag), .fb_out(fbo), .fb_in(fbi));

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Strap settles while reset is held, as a board would wire it
  task do_reset(input logic [3:0] code);
    @(negedge clock);
    rst = 1'b1;
    ratio_sel = code;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
  endtask

  // Count cache clock edges over a window of core cycles
  task count_edges(input int cycles, output int n);
    logic prev;
    n = 0;
    prev = cco;
    repeat (cycles) begin
      @(negedge clock);
      if (cco !== prev) n++;
      prev = cco;
    end
  endtask

  // Every strap code, reserved one included
  task t_decode;
    logic [4:0] tab [16];
    logic       pe;
    tab = '{5'h00, 5'h0f, 5'h0e, 5'h02, 5'h04, 5'h0d, 5'h14, 5'h09,
            5'h06, 5'h0b, 5'h08, 5'h0a, 5'h10, 5'h0c, 5'h07, 5'h00};
    for (int i = 0; i < 16; i++) begin
      do_reset(4'(i));
      pe = (i != 0 && i != 3 && i != 15);
      check(8'(mult), 8'(tab[i]));
      check(8'(vco), 8'(pe ? {tab[i], 1'b0} : 6'h00));
      check(8'(pll_en), 8'(pe));
      check(8'(byp), 8'(ratio_sel == RSEL_BYP));
      check(8'(run), 8'(i != 0 && i != 15));
      check(8'(rsvd), 8'(i == 0));
    end
  endtask

  // Each divisor code; window of 30 holds whole repeats of every divider tick pattern
  task t_divider;
    logic [5:0] exp [8];
    int         n;
    exp = '{6'h00, 6'h1e, 6'h14, 6'h0f, 6'h0c, 6'h0a, 6'h00, 6'h00};
    do_reset(RSEL_2X0);
    for (int d = 0; d < 8; d++) begin
      div = 3'(d);
      repeat (10) @(negedge clock);
      count_edges(30, n);
      check(8'(n), 8'(exp[d]));
      if (d == 0) check(8'(lock), 8'h01);
    end
  endtask

  // Slow return path: one sent edge comes back late, then the loop relocks
  task t_lag;
    do_reset(RSEL_3X0);
    lag = 2'h3;
    div = CDIV_OFF;
    repeat (10) @(negedge clock);
    div = CDIV_1X0;
    @(negedge clock);
    div = CDIV_OFF;
    repeat (3) @(negedge clock);
    check(8'(lead), 8'h01);
    check(8'(lock), 8'h00);
    repeat (20) @(negedge clock);
    check(8'(lock), 8'h01);
    check(8'(cco), 8'h01);
    lag = 2'h0;
  endtask

  // Off strap: no cache clock and no lock even with a divisor set
  task t_off;
    int n;
    do_reset(RSEL_OFF);
    div = CDIV_1X0;
    count_edges(20, n);
    check(8'(n), 8'h00);
    check(8'(lock), 8'h00);
  endtask

  // Slow flag follows one cycle later, both ways
  task t_slow;
    do_reset(RSEL_4X0);
    // Divisor kept at a legal rate, flag driven high then low
    div = CDIV_2X5;
    for (int v = 1; v >= 0; v--) begin
      slow = 1'(v);
      @(negedge clock);
      check(8'(slow_m), 8'(v));
    end
  endtask

  initial begin
    t_decode;
    t_divider;
    t_lag;
    t_off;
    t_slow;
    end_sim;
  end

  // Watchdog well past the five hundred or so cycles the tests need
  initial begin
    #50000;
    failures++;
    end_sim;
  end
endmodule

bind ccrc_top ccrc_top_chk chk (.clock(clock), .rst(rst), .ratio_sel(ratio_sel),
  .cache_clock_divisor(cache_clock_divisor), .slow_cache_clock_flag(slow_cache_clock_flag),
  .cache_clock_feedback_in(cache_clock_feedback_in), .core_mult_half(core_mult_half),
  .vco_mult_half(vco_mult_half), .pll_enable(pll_enable), .pll_bypass(pll_bypass),
  .core_clock_run(core_clock_run), .ratio_reserved(ratio_reserved),
  .cache_clock_out(cache_clock_out), .cache_clock_feedback_out(cache_clock_feedback_out),
  .cache_slow_mode(cache_slow_mode), .feedback_locked(feedback_locked),
  .feedback_lead(feedback_lead));
